// >>> rtl/motor_pkg.sv
// Purpose: Build options, timing counts and register map of the commutator
// Assumes: 100 MHz system clock, 3.58 MHz reference made by an NCO
// Notes: All build options are fixed here; only the enable bit in REG_CTRL is set at run time
package motor_pkg;
   typedef enum {SEP_60, SEP_120, SEP_240, SEP_300} hall_sep_e;

   // Clock and reference
   localparam int CLK_HZ = 100_000_000;
   localparam int REF_HZ = 3_580_000;
   localparam logic [31:0] NCO_INC =
      32'((64'(REF_HZ) << 32) / 64'(CLK_HZ));

   // Build options
   localparam int PHASES = 3;
   localparam hall_sep_e HALL_SEP = SEP_60;
   localparam logic [1:0] TACH_SEL = 2'h0;
   localparam int TACH_DIV = 1;
   localparam int POLES = 4;
   localparam int GAIN_HIGH = 0;
   localparam int TARGET_ONES = 5;

   // Derived counts
   localparam int TARGET_RPM = 3600;
   localparam int BAND_RPM = (GAIN_HIGH != 0) ? 6 : 40;
   localparam int LAT_W = 15;
   localparam int ACC_W = 16;
   localparam int SHIFT_DIV = (POLES == 8) ? 192 : 384;
   localparam int DIV_W = 9;
   localparam int TARGET_CNT =
      (REF_HZ * 60 * TACH_DIV) / (TARGET_RPM * (POLES / 2));
   localparam int STEP_RAW = (TARGET_CNT * BAND_RPM) / (TARGET_RPM * LAT_W);
   localparam int STEP_CNT = (STEP_RAW < 1) ? 1 : STEP_RAW;
   localparam logic [2:0] STEP_NONE = 3'h7;

   // Register map
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_LATCH = 8'h08;
   localparam logic [ADDR_W-1:0] REG_PERIOD = 8'h0C;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RST = 1'b0;
   localparam int ST_ONES_LSB = 0;
   localparam int ST_STEP_LSB = 4;
   localparam int ST_BRAKE_BIT = 8;
   localparam int ST_OC_BIT = 9;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : motor_pkg

// >>> rtl/fixed_speed_motor_commutator.sv
// Purpose: Fixed speed regulator and commutator for a brushless DC motor
// Assumes: Hall, brake and overcurrent inputs arrive unsynchronised
// Notes: AXI4-Lite slave for enable and status
// Operation
// R1: Tachometer taken from one fixed Hall input
// R2: Tachometer prescaled by fixed 1, 2 or 4
// R3: Prescaler event loads latches, clears accumulator
// R4: Accumulator counts reference clocks between events
// R5: Count addresses 15-output thermometer look-up
// R6: Duty proportional to ones in latch
// R7: Slow gives all ones, fast all zeros
// R8: Table thresholds set loop gain, 40/6 RPM
// R9: Latch loads shift register each commutation
// R10: Shift clock divides reference by 384/192
// R11: All 15 bits shift out, gate winding
// R12: Winding on once per interval, no chopping
// R13: Three-phase Hall spacing 60/120/240/300 option
// R14: Four-phase variant uses 90 degree sensors
// R15: Three sink, three source outputs driven
// R16: Overcurrent switches every driver off
// R17: Brake: sinks off, sources on
// R18: Hold 3600 RPM from 3.58 MHz reference
// R19: Duty at target between 30 and 70 percent
// R20: Brake overrides overcurrent
// R21: Accumulator saturates instead of wrapping
// R22: Hall inputs synchronised before edge detection
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
module fixed_speed_motor_commutator (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [2:0] hallIn,
   input wire logic overcurrent,
   input wire logic brake,
   output logic [2:0] sinkOn,
   output logic [2:0] sourceOn,
   input wire logic [motor_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [motor_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import motor_pkg::*;

   // Hall position to commutation step, STEP_NONE for illegal codes
   function automatic logic [2:0] hall_step(input logic [2:0] h);
      logic [2:0] c;
      logic [2:0] s;
      c = h;
      if (HALL_SEP == SEP_240 || HALL_SEP == SEP_300) begin
         c = {h[1], h[2], h[0]};
      end
      s = STEP_NONE;
      if (HALL_SEP == SEP_60 || HALL_SEP == SEP_300) begin
         case (c)
            3'b001: s = 3'h0;
            3'b011: s = 3'h1;
            3'b111: s = 3'h2;
            3'b110: s = 3'h3;
            3'b100: s = 3'h4;
            3'b000: s = 3'h5;
            default: s = STEP_NONE;
         endcase
      end else begin
         case (c)
            3'b001: s = 3'h0;
            3'b011: s = 3'h1;
            3'b010: s = 3'h2;
            3'b110: s = 3'h3;
            3'b100: s = 3'h4;
            3'b101: s = 3'h5;
            default: s = STEP_NONE;
         endcase
      end
      return s;
   endfunction : hall_step

   function automatic logic [3:0] ones_count(input logic [LAT_W-1:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < LAT_W; i++) begin
         n = n + {3'h0, v[i]};
      end
      return n;
   endfunction : ones_count

   // Reference clock from NCO
   logic [31:0] refPhase_r;
   logic [32:0] refSum;
   logic refTick;
   assign refSum = {1'b0, refPhase_r} + {1'b0, NCO_INC};
   assign refTick = refSum[32]; // R18

   // Input synchronisers
   logic [2:0] hallMeta_r;
   logic [2:0] hallSync_r;
   logic [2:0] hallPrev_r;
   logic [1:0] ctlMeta_r;
   logic [1:0] ctlSync_r;
   logic tachRise;
   logic commStart;
   assign tachRise = hallSync_r[TACH_SEL] & ~hallPrev_r[TACH_SEL]; // R1 R22
   assign commStart = hallSync_r != hallPrev_r;

   // Prescaler
   logic [1:0] preCnt_r;
   logic preEvent;
   assign preEvent = tachRise && (preCnt_r == 2'(TACH_DIV - 1)); // R2

   // Accumulator and look-up
   logic [ACC_W-1:0] accCnt_r;
   logic [ACC_W-1:0] period_r;
   logic [LAT_W-1:0] lutOut;
   logic [LAT_W-1:0] latch_r;
   logic accFull;
   assign accFull = &accCnt_r;

   for (genvar i = 0; i < LAT_W; i++) begin : g_lut
      localparam int THR = TARGET_CNT - (TARGET_ONES - 1 - i) * STEP_CNT;
      // Thermometer: lower bits set first as the count rises
      assign lutOut[i] = accCnt_r >= ACC_W'(THR); // R5 R7 R8 R19
   end

   // Shift register and its clock divider
   logic [LAT_W-1:0] shift_r;
   logic [DIV_W-1:0] divCnt_r;
   logic shiftTick;
   logic gateOn;
   assign shiftTick = refTick && (divCnt_r == DIV_W'(SHIFT_DIV - 1)); // R10
   assign gateOn = shift_r[0]; // R6 R11 R12

   // Commutation decoder
   logic ctrlEn_r;
   logic [2:0] step;
   logic [2:0] rawSink;
   logic [2:0] rawSource;
   logic [2:0] sinkNxt;
   logic [2:0] sourceNxt;
   logic [2:0] sinkOn_r;
   logic [2:0] sourceOn_r;
   assign step = hall_step(hallSync_r); // R13

   always_comb begin
      rawSink = 3'h0;
      rawSource = 3'h0;
      if (PHASES == 4) begin
         case ({hallSync_r[0], hallSync_r[1]}) // R14
            2'b00: rawSink = 3'b001;
            2'b10: rawSink = 3'b100;
            2'b11: rawSource = 3'b001;
            2'b01: rawSource = 3'b100;
            default: rawSink = 3'h0;
         endcase
      end else begin
         case (step) // R15
            3'h0: begin
               rawSink = 3'b100;
               rawSource = 3'b010;
            end
            3'h1: begin
               rawSink = 3'b100;
               rawSource = 3'b001;
            end
            3'h2: begin
               rawSink = 3'b010;
               rawSource = 3'b001;
            end
            3'h3: begin
               rawSink = 3'b010;
               rawSource = 3'b100;
            end
            3'h4: begin
               rawSink = 3'b001;
               rawSource = 3'b100;
            end
            3'h5: begin
               rawSink = 3'b001;
               rawSource = 3'b010;
            end
            default: begin
               rawSink = 3'h0;
               rawSource = 3'h0;
            end
         endcase
      end
   end

   always_comb begin
      if (ctlSync_r[1]) begin
         sinkNxt = 3'h0; // R17 R20
         sourceNxt = 3'h7; // R17 R20
      end else if (ctlSync_r[0] || !ctrlEn_r) begin
         sinkNxt = 3'h0; // R16
         sourceNxt = 3'h0; // R16
      end else begin
         sinkNxt = gateOn ? rawSink : 3'h0;
         sourceNxt = gateOn ? rawSource : 3'h0;
      end
   end

   assign sinkOn = sinkOn_r;
   assign sourceOn = sourceOn_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         refPhase_r <= 32'h0000_0000;
         hallMeta_r <= 3'h0;
         hallSync_r <= 3'h0;
         hallPrev_r <= 3'h0;
         ctlMeta_r <= 2'h0;
         ctlSync_r <= 2'h0;
      end else if (ce) begin
         refPhase_r <= refSum[31:0];
         hallMeta_r <= hallIn; // R22
         hallSync_r <= hallMeta_r;
         hallPrev_r <= hallSync_r;
         ctlMeta_r <= {brake, overcurrent};
         ctlSync_r <= ctlMeta_r;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         preCnt_r <= 2'h0;
         accCnt_r <= 16'h0000;
         period_r <= 16'h0000;
         latch_r <= 15'h0000;
      end else if (ce) begin
         if (tachRise) begin
            preCnt_r <= preEvent ? 2'h0 : preCnt_r + 2'h1; // R2
         end
         if (preEvent) begin
            latch_r <= lutOut; // R3
            period_r <= accCnt_r;
            accCnt_r <= 16'h0000; // R3
         end else if (refTick && !accFull) begin
            accCnt_r <= accCnt_r + 16'h0001; // R4 R21
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         shift_r <= 15'h0000;
         divCnt_r <= 9'h000;
         sinkOn_r <= 3'h0;
         sourceOn_r <= 3'h0;
      end else if (ce) begin
         sinkOn_r <= sinkNxt;
         sourceOn_r <= sourceNxt;
         if (commStart) begin
            shift_r <= latch_r; // R9
            divCnt_r <= 9'h000;
         end else if (shiftTick) begin
            shift_r <= {1'b0, shift_r[LAT_W-1:1]}; // R11
            divCnt_r <= 9'h000;
         end else if (refTick) begin
            divCnt_r <= divCnt_r + 9'h001;
         end
      end
   end

   // AXI4-Lite write side
   logic awHeld_r;
   logic wHeld_r;
   logic [ADDR_W-1:0] awAddr_r;
   logic [31:0] wData_r;
   logic wLane0_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic doWrite;
   logic wrCtrl;
   // Readies follow ce so that no handshake is lost while frozen
   assign s_axi_awready = ce && !awHeld_r && !bvalid_r;
   assign s_axi_wready = ce && !wHeld_r && !bvalid_r;
   assign doWrite = awHeld_r && wHeld_r && !bvalid_r;
   assign wrCtrl = awAddr_r == REG_CTRL;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= 8'h00;
         wData_r <= 32'h0000_0000;
         wLane0_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         ctrlEn_r <= CTRL_EN_RST;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wLane0_r <= s_axi_wstrb[0];
         end
         if (doWrite) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wrCtrl ? RESP_OKAY : RESP_SLVERR;
            if (wrCtrl && wLane0_r) begin
               ctrlEn_r <= wData_r[CTRL_EN_BIT];
            end
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // AXI4-Lite read side
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [31:0] rdMux;
   logic rdHit;
   logic [31:0] statusWord;
   assign statusWord = (32'(ones_count(latch_r)) << ST_ONES_LSB)
      | (32'(step) << ST_STEP_LSB)
      | (32'(ctlSync_r[1]) << ST_BRAKE_BIT)
      | (32'(ctlSync_r[0]) << ST_OC_BIT);
   assign rdHit = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_STATUS)
      || (s_axi_araddr == REG_LATCH) || (s_axi_araddr == REG_PERIOD);
   assign rdMux = (s_axi_araddr == REG_CTRL) ? 32'(ctrlEn_r) :
      (s_axi_araddr == REG_STATUS) ? statusWord :
      (s_axi_araddr == REG_LATCH) ? 32'(latch_r) :
      (s_axi_araddr == REG_PERIOD) ? 32'(period_r) : 32'h0000_0000;
   assign s_axi_arready = ce && !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r <= rdMux;
            rresp_r <= rdHit ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end
endmodule : fixed_speed_motor_commutator

// >>> verification/motor_commutator_chk.sv
// Purpose: Port level assertions for the motor commutator
// Assumes: ce held high, inputs pass two sync stages and an output stage
// Notes: Bound into the commutator below
module motor_commutator_chk (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic brake,
   input wire logic overcurrent,
   input wire logic [2:0] sinkOn,
   input wire logic [2:0] sourceOn,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   a_brake_pattern: assert property (brake [*4] |->
      sinkOn == 3'h0 && sourceOn == 3'h7) else $error("brake pattern");
   a_oc_shutdown: assert property ((overcurrent && !brake) [*4] |->
      sinkOn == 3'h0 && sourceOn == 3'h0) else $error("overcurrent drive");
   a_brake_wins: assert property ((brake && overcurrent) [*4] |->
      sinkOn == 3'h0 && sourceOn == 3'h7) else $error("brake priority");
   a_sink_onehot: assert property ($onehot0(sinkOn))
      else $error("two sinks on");
   a_source_onehot: assert property (!brake [*4] |->
      $onehot0(sourceOn)) else $error("two sources on");
   a_no_shoot: assert property ((sinkOn & sourceOn) == 3'h0)
      else $error("sink and source of one phase on");
   a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while response pending");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
endmodule : motor_commutator_chk

bind fixed_speed_motor_commutator motor_commutator_chk chk (
   .clk_sys, .rst_n, .brake, .overcurrent, .sinkOn, .sourceOn,
   .s_axi_awready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid
);

// >>> verification/motor_side_model.sv
// Purpose: Hall sensors and power stage seen from the commutator
// Assumes: Rotor position given as a three bit Hall code
// Notes: Sensor edges land off the clock grid
module motor_side_model (
   input wire logic [2:0] codeReq,
   input wire logic [2:0] sinkOn,
   input wire logic [2:0] sourceOn,
   output logic [2:0] hallIn,
   output logic shootThrough
);
   timeunit 1ns;
   timeprecision 100ps;
   // Rotor moves independently of the system clock
   assign #3 hallIn = codeReq;
   // Both drivers of one phase on would short the supply
   assign shootThrough = |(sinkOn & sourceOn);
endmodule : motor_side_model

// >>> verification/fixed_speed_motor_commutator_tb_top.sv
// Purpose: Self-checking bench for the fixed speed motor commutator
// Assumes: Build options as set in motor_pkg, ce held high
// Notes: Latch stays all zeros: a slow motor needs too many cycles
module fixed_speed_motor_commutator_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import motor_pkg::*;
   logic clk_sys;
   logic rst_n;
   logic ce;
   logic overcurrent;
   logic brake;
   logic [2:0] codeReq;
   logic [2:0] hallIn;
   logic [2:0] sinkOn;
   logic [2:0] sourceOn;
   logic shootThrough;
   logic [7:0] s_axi_awaddr;
   logic s_axi_awvalid;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_wvalid;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready;
   logic [7:0] s_axi_araddr;
   logic s_axi_arvalid;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready;
   logic [31:0] rd;
   logic [1:0] rsp;
   longint tRise;
   longint expRef;
   int fails;
   int checks;
   // Step index for each Hall code at 60 degree spacing
   logic [2:0] stepOf [8] =
      '{3'h5, 3'h0, 3'h7, 3'h1, 3'h4, 3'h7, 3'h3, 3'h2};

   fixed_speed_motor_commutator dut (
      .clk_sys, .rst_n, .ce, .hallIn, .overcurrent, .brake, .sinkOn,
      .sourceOn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready
   );
   motor_side_model motor (
      .codeReq, .sinkOn, .sourceOn, .hallIn, .shootThrough
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic timeout;
      check(32'h0, 32'h1);
      tally_and_finish();
   endtask : timeout

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] st, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
         s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      if (s_axi_bvalid !== 1'b1) timeout();
      check(32'(s_axi_bresp), 32'(er));
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
         output logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      if (s_axi_rvalid !== 1'b1) timeout();
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask : axi_read

   task automatic read_check(input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] exp, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      axi_read(a, d, r);
      check(d & m, exp);
      check(32'(r), 32'(er));
   endtask : read_check

   task automatic hold_drive(input int n, input logic [5:0] exp);
      repeat (n) @(posedge clk_sys);
      check(32'({sinkOn, sourceOn}), 32'(exp));
   endtask : hold_drive

   initial begin
      {rst_n, brake, overcurrent, codeReq, fails, checks} = '0;
      ce = 1'b1;
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      hold_drive(1, 6'h00);
      read_check(REG_CTRL, 32'h1, 32'h0, RESP_OKAY);
      axi_write(REG_STATUS, 32'h1, 4'hF, RESP_SLVERR);
      axi_write(8'h10, 32'h1, 4'hF, RESP_SLVERR);
      read_check(8'h10, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
      axi_write(REG_CTRL, 32'h1, 4'h0, RESP_OKAY);
      read_check(REG_CTRL, 32'h1, 32'h0, RESP_OKAY);
      axi_write(REG_CTRL, 32'h1, 4'hF, RESP_OKAY);
      read_check(REG_CTRL, 32'h1, 32'h1, RESP_OKAY);
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         codeReq <= 3'(i);
         repeat (8) @(posedge clk_sys);
         read_check(REG_STATUS, 32'h70, 32'(stepOf[i]) << 4, RESP_OKAY);
         check(32'(shootThrough), 32'h0);
      end
      $display("test hall steps done");
      codeReq <= 3'h0;
      repeat (20) @(posedge clk_sys);
      codeReq <= 3'h1;
      tRise = $time;
      for (int k = 1; k <= 2; k++) begin
         repeat (k * 700) @(posedge clk_sys);
         codeReq <= 3'h0;
         repeat (k * 700) @(posedge clk_sys);
         expRef = (($time - tRise) / 10) * REF_HZ / CLK_HZ;
         tRise = $time;
         codeReq <= 3'h1;
         repeat (20) @(posedge clk_sys);
         axi_read(REG_PERIOD, rd, rsp);
         check(32'(rd + 2 >= expRef && rd <= expRef + 2), 32'h1);
      end
      read_check(REG_LATCH, 32'h7FFF, 32'h0, RESP_OKAY);
      read_check(REG_STATUS, 32'hF, 32'h0, RESP_OKAY);
      hold_drive(1, 6'h00);
      $display("test speed measure done");
      brake <= 1'b1;
      hold_drive(2, 6'h00);
      hold_drive(2, 6'h07);
      overcurrent <= 1'b1;
      hold_drive(4, 6'h07);
      read_check(REG_STATUS, 32'h300, 32'h300, RESP_OKAY);
      brake <= 1'b0;
      hold_drive(4, 6'h00);
      overcurrent <= 1'b0;
      axi_write(REG_CTRL, 32'h0, 4'hF, RESP_OKAY);
      brake <= 1'b1;
      hold_drive(4, 6'h07);
      brake <= 1'b0;
      hold_drive(4, 6'h00);
      $display("test brake done");
      axi_write(REG_CTRL, 32'h1, 4'hF, RESP_OKAY);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      hold_drive(1, 6'h00);
      read_check(REG_CTRL, 32'h1, 32'h0, RESP_OKAY);
      $display("test reset done");
      tally_and_finish();
   end
endmodule : fixed_speed_motor_commutator_tb_top
